// >>> src/srs_pkg.sv
package srs_pkg;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_LOCK    = 16'hF600;
  localparam logic [15:0] IDX_CTRL    = 16'hF601;
  localparam logic [15:0] IDX_DECODE  = 16'hF602;
  localparam logic [15:0] IDX_CODE    = 16'hF603;
  localparam logic [15:0] IDX_RESUME  = 16'hF604;
  localparam logic [15:0] IDX_STICKY  = 16'hF605;
  localparam logic [15:0] IDX_IRQ_ST  = 16'hF610;
  localparam logic [15:0] IDX_IRQ_CLR = 16'hF611;
  localparam logic [15:0] IDX_IRQ_EN  = 16'hF612;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int WL_R_LSB   = 6;
  localparam int WL_L_LSB   = 2;
  localparam int FAMILY_BIT = 1;
  localparam int AUDIO_BIT  = 0;
  localparam int QUICK_BIT  = 3;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam int IRQ_W      = 3;
  localparam int IRQ_LOCK   = 0;
  localparam int IRQ_LOST   = 1;
  localparam int IRQ_FMT    = 2;

  // ----------------------------------------------------------------
  // Lock thresholds in consecutive valid samples
  // ----------------------------------------------------------------
  localparam logic [6:0] LOCK_NORMAL = 7'h40;
  localparam logic [6:0] LOCK_QUICK  = 7'h08;

  // ----------------------------------------------------------------
  // Detected word length codes
  // ----------------------------------------------------------------
  localparam logic [3:0] WL16 = 4'h2;
  localparam logic [3:0] WL17 = 4'hC;
  localparam logic [3:0] WL18 = 4'h4;
  localparam logic [3:0] WL19 = 4'h8;
  localparam logic [3:0] WL20 = 4'hA;
  localparam logic [3:0] WL20M24 = 4'h3;
  localparam logic [3:0] WL21 = 4'hD;
  localparam logic [3:0] WL22 = 4'h5;
  localparam logic [3:0] WL23 = 4'h9;
  localparam logic [3:0] WL24 = 4'hB;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic        stb;
    logic        ok;
    logic [3:0]  wl_left;
    logic [3:0]  wl_right;
    logic        compressed;
    logic        family;
    logic [15:0] code;
    logic [23:0] left;
    logic [23:0] right;
  } srs_frame_s;

  typedef struct packed {
    logic        stb;
    logic [23:0] left;
    logic [23:0] right;
  } srs_audio_s;

  typedef enum logic [1:0] {
    SL_IDLE = 2'b01,
    SL_READ = 2'b10
  } srs_slv_e;

endpackage

// >>> src/srs_lock_det.sv
`timescale 1ns/100ps
module srs_lock_det (
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  input  wire logic smp_stb_in,
  input  wire logic smp_ok_in,
  input  wire logic quick_in,
  output logic      locked_out
);

  logic [6:0] run_ff;
  logic [6:0] nxt_run;
  logic [6:0] need;
  logic       nxt_locked;

  // ----------------------------------------------------------------
  // Consecutive valid sample counter
  // ----------------------------------------------------------------
  // One bad sample drops lock at once and restarts the count
  assign need = quick_in ? srs_pkg::LOCK_QUICK : srs_pkg::LOCK_NORMAL;
  assign nxt_run = !smp_stb_in ? run_ff :
                   !smp_ok_in ? 7'h00 :
                   (run_ff == need) ? run_ff : run_ff + 7'h01;
  assign nxt_locked = smp_stb_in ? (smp_ok_in && nxt_run == need) : locked_out;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_ff     <= 7'h00;
      locked_out <= 1'b0;
    end else begin
      run_ff     <= nxt_run;
      locked_out <= nxt_locked;
    end
  end

endmodule

// >>> src/srs_ahb_slv.sv
`timescale 1ns/100ps
module srs_ahb_slv (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  input  wire logic [15:0] rdata_in,
  output logic [15:0]      rd_idx_out,
  output logic [15:0]      wr_idx_out,
  output logic             wr_en_out,
  output logic [15:0]      wr_data_out,
  output logic             hreadyout_out,
  output logic [31:0]      hrdata_out
);

  srs_pkg::srs_slv_e state_ff;
  srs_pkg::srs_slv_e nxt_state;
  logic              wr_pend_ff;
  logic [15:0]       idx_ff;
  logic              take;
  logic              mapped;

  // ----------------------------------------------------------------
  // Address phase decode
  // ----------------------------------------------------------------
  assign take = hsel_in && hready_in && htrans_in == srs_pkg::HTRANS_NONSEQ
                && hsize_in == srs_pkg::HSIZE_WORD;
  assign mapped = haddr_in[31:18] == 14'h0000 && haddr_in[1:0] == 2'b00;
  // Reads take one wait state so a write just before is already stored
  assign wr_en_out   = wr_pend_ff;
  assign wr_idx_out  = idx_ff;
  assign wr_data_out = hwdata_in[15:0];
  assign rd_idx_out  = idx_ff;

  always_comb begin
    nxt_state = srs_pkg::SL_IDLE;
    case (state_ff)
      srs_pkg::SL_IDLE: begin
        if (take && !hwrite_in) begin
          nxt_state = srs_pkg::SL_READ;
        end
      end
      default: begin
        nxt_state = srs_pkg::SL_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff      <= srs_pkg::SL_IDLE;
      wr_pend_ff    <= 1'b0;
      idx_ff        <= 16'h0000;
      hreadyout_out <= 1'b1;
      hrdata_out    <= 32'h0000_0000;
    end else begin
      state_ff      <= nxt_state;
      wr_pend_ff    <= take && hwrite_in && mapped;
      hreadyout_out <= !(take && !hwrite_in);
      if (take) begin
        idx_ff <= mapped ? haddr_in[17:2] : 16'h0000;
      end
      if (state_ff == srs_pkg::SL_READ) begin
        hrdata_out <= {16'h0000, rdata_in};
      end
    end
  end

endmodule

// >>> src/srs_status_top.sv
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/100ps
module srs_status_top (
  input  wire logic                sys_clk_in,
  input  wire logic                rst_in,
  input  wire logic                hsel_in,
  input  wire logic [31:0]         haddr_in,
  input  wire logic [1:0]          htrans_in,
  input  wire logic                hwrite_in,
  input  wire logic [2:0]          hsize_in,
  input  wire logic [31:0]         hwdata_in,
  input  wire logic                hready_in,
  input  wire srs_pkg::srs_frame_s frame_in,
  output logic                     hreadyout_out,
  output logic [31:0]              hrdata_out,
  output logic                     hresp_out,
  output srs_pkg::srs_audio_s      audio_out,
  output logic                     mute_out,
  output logic                     irq_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int IRQ_W_M1 = srs_pkg::IRQ_W - 1;

  logic [15:0]         rd_idx;
  logic [15:0]         wr_idx;
  logic                wr_en;
  logic [15:0]         wr_data;
  logic [15:0]         rdata;
  logic                locked;
  logic                locked_d_ff;
  logic                lock_rise;
  logic                lock_fall;
  logic                quick_ff;
  logic [2:0]          ctrl_rest_ff;
  logic                resume_ff;
  logic                sticky_ff;
  logic                nxt_sticky;
  logic                halted_ff;
  logic                nxt_halted;
  logic                seen_lock_ff;
  logic [3:0]          wl_l_ff;
  logic [3:0]          wl_r_ff;
  logic                compressed_ff;
  logic                family_ff;
  logic [15:0]         code_ff;
  logic [15:0]         nxt_code;
  logic [3:0]          nxt_wl [2];
  logic                wl_known [2];
  logic [3:0]          wl_raw [2];
  logic                take_fmt;
  logic                fmt_change;
  logic [15:0]         decode_word;
  logic [IRQ_W_M1:0]   irq_st_ff;
  logic [IRQ_W_M1:0]   irq_en_ff;
  logic [IRQ_W_M1:0]   irq_evt;
  logic [IRQ_W_M1:0]   irq_clr;
  logic [IRQ_W_M1:0]   nxt_irq_st;
  logic                wr_ctrl;
  logic                wr_resume;
  logic                wr_irq_clr;
  logic                wr_irq_en;
  logic                play;
  srs_pkg::srs_audio_s nxt_audio;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  srs_ahb_slv u_slv (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .hsel_in       (hsel_in),
    .haddr_in      (haddr_in),
    .htrans_in     (htrans_in),
    .hwrite_in     (hwrite_in),
    .hsize_in      (hsize_in),
    .hwdata_in     (hwdata_in),
    .hready_in     (hready_in),
    .rdata_in      (rdata),
    .rd_idx_out    (rd_idx),
    .wr_idx_out    (wr_idx),
    .wr_en_out     (wr_en),
    .wr_data_out   (wr_data),
    .hreadyout_out (hreadyout_out),
    .hrdata_out    (hrdata_out)
  );

  // ----------------------------------------------------------------
  // Lock detection
  // ----------------------------------------------------------------
  srs_lock_det u_lock (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .smp_stb_in (frame_in.stb),
    .smp_ok_in  (frame_in.ok),
    .quick_in   (quick_ff),
    .locked_out (locked)
  );

  assign lock_rise = locked && !locked_d_ff;
  assign lock_fall = !locked && locked_d_ff;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Only the writable registers decode; status indices fall through
  assign wr_ctrl    = wr_en && wr_idx == srs_pkg::IDX_CTRL;
  assign wr_resume  = wr_en && wr_idx == srs_pkg::IDX_RESUME;
  assign wr_irq_clr = wr_en && wr_idx == srs_pkg::IDX_IRQ_CLR;
  assign wr_irq_en  = wr_en && wr_idx == srs_pkg::IDX_IRQ_EN;

  // ----------------------------------------------------------------
  // Mute and restart
  // ----------------------------------------------------------------
  // Halt is raised only by losing a lock that was held, so the very
  // first acquisition after reset plays without software help.
  // A loss in the same cycle as resume=1 still halts: set wins.
  assign nxt_halted = lock_fall ? 1'b1 :
                      resume_ff ? 1'b0 : halted_ff;
  assign nxt_sticky = (lock_fall && seen_lock_ff) ? 1'b1 :
                      resume_ff ? 1'b0 : sticky_ff;
  assign play       = locked && !nxt_halted;

  assign nxt_audio.stb   = play && frame_in.stb;
  assign nxt_audio.left  = play ? frame_in.left : 24'h000000;
  assign nxt_audio.right = play ? frame_in.right : 24'h000000;

  // ----------------------------------------------------------------
  // Stream decode
  // ----------------------------------------------------------------
  // Only good frames under lock update the format fields
  assign take_fmt  = frame_in.stb && frame_in.ok && locked;
  assign wl_raw[0] = frame_in.wl_left;
  assign wl_raw[1] = frame_in.wl_right;

  // Codes outside the set read back as zero, never as garbage
  for (genvar ch = 0; ch < 2; ch++) begin : g_wl
    assign wl_known[ch] = wl_raw[ch] == srs_pkg::WL16 || wl_raw[ch] == srs_pkg::WL17
                          || wl_raw[ch] == srs_pkg::WL18 || wl_raw[ch] == srs_pkg::WL19
                          || wl_raw[ch] == srs_pkg::WL20 || wl_raw[ch] == srs_pkg::WL20M24
                          || wl_raw[ch] == srs_pkg::WL21 || wl_raw[ch] == srs_pkg::WL22
                          || wl_raw[ch] == srs_pkg::WL23 || wl_raw[ch] == srs_pkg::WL24;
    assign nxt_wl[ch] = wl_known[ch] ? wl_raw[ch] : 4'h0;
  end

  assign nxt_code = frame_in.compressed ? frame_in.code : code_ff;
  assign fmt_change = take_fmt && (nxt_wl[0] != wl_l_ff || nxt_wl[1] != wl_r_ff
                                   || frame_in.compressed != compressed_ff
                                   || frame_in.family != family_ff);

  assign decode_word = {6'h00,
                        wl_r_ff,
                        wl_l_ff,
                        family_ff && compressed_ff,
                        compressed_ff};

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign irq_evt[srs_pkg::IRQ_LOCK] = lock_rise;
  assign irq_evt[srs_pkg::IRQ_LOST] = lock_fall;
  assign irq_evt[srs_pkg::IRQ_FMT]  = fmt_change;
  assign irq_clr    = wr_irq_clr ? wr_data[IRQ_W_M1:0] : '0;
  // Set beats clear so an event in the clearing cycle is kept
  assign nxt_irq_st = irq_evt | (irq_st_ff & ~irq_clr);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped indices and the write-only clear read as zero
  assign rdata = (rd_idx == srs_pkg::IDX_LOCK)   ? {15'h0000, locked} :
                 (rd_idx == srs_pkg::IDX_CTRL)   ? {12'h000, quick_ff, ctrl_rest_ff} :
                 (rd_idx == srs_pkg::IDX_DECODE) ? decode_word :
                 (rd_idx == srs_pkg::IDX_CODE)   ? code_ff :
                 (rd_idx == srs_pkg::IDX_RESUME) ? {15'h0000, resume_ff} :
                 (rd_idx == srs_pkg::IDX_STICKY) ? {15'h0000, sticky_ff} :
                 (rd_idx == srs_pkg::IDX_IRQ_ST) ? {13'h0000, irq_st_ff} :
                 (rd_idx == srs_pkg::IDX_IRQ_EN) ? {13'h0000, irq_en_ff} : 16'h0000;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      quick_ff     <= 1'b0;
      ctrl_rest_ff <= 3'h0;
      resume_ff    <= 1'b0;
      irq_en_ff    <= '0;
    end else begin
      if (wr_ctrl) begin
        quick_ff     <= wr_data[srs_pkg::QUICK_BIT];
        ctrl_rest_ff <= wr_data[2:0];
      end
      if (wr_resume) begin
        resume_ff <= wr_data[0];
      end
      if (wr_irq_en) begin
        irq_en_ff <= wr_data[IRQ_W_M1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Lock history
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      locked_d_ff  <= 1'b0;
      halted_ff    <= 1'b0;
      sticky_ff    <= 1'b0;
      seen_lock_ff <= 1'b0;
    end else begin
      locked_d_ff  <= locked;
      halted_ff    <= nxt_halted;
      sticky_ff    <= nxt_sticky;
      seen_lock_ff <= seen_lock_ff || lock_rise;
    end
  end

  // ----------------------------------------------------------------
  // Decoded format
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wl_l_ff       <= 4'h0;
      wl_r_ff       <= 4'h0;
      compressed_ff <= 1'b0;
      family_ff     <= 1'b0;
      code_ff       <= srs_pkg::REG_RST;
    end else if (take_fmt) begin
      wl_l_ff       <= nxt_wl[0];
      wl_r_ff       <= nxt_wl[1];
      compressed_ff <= frame_in.compressed;
      family_ff     <= frame_in.family;
      code_ff       <= nxt_code;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      audio_out <= '0;
      mute_out  <= 1'b1;
      irq_st_ff <= '0;
      irq_out   <= 1'b0;
      hresp_out <= 1'b0;
    end else begin
      audio_out <= nxt_audio;
      mute_out  <= !play;
      irq_st_ff <= nxt_irq_st;
      irq_out   <= |(nxt_irq_st & irq_en_ff);
      hresp_out <= 1'b0;
    end
  end

endmodule

// >>> bench/srs_src_model.sv
`timescale 1ns/100ps
module srs_src_model (
  input  wire logic           sys_clk_in,
  output srs_pkg::srs_frame_s frame_out
);
  // ----------------------------------------------------------------
  // Source state
  // ----------------------------------------------------------------
  srs_pkg::srs_frame_s last;
  logic [23:0]         cnt = 24'h000000;

  initial frame_out = '0;

  // Idle lines show the inverse of the last frame, so a stale copy is never mistaken for data
  task automatic send(input int n, input logic ok, input logic [3:0] l, input logic [3:0] r,
                      input logic cmp, input logic fam, input logic slow);
    srs_pkg::srs_frame_s g;
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_in);
      cnt = cnt + 24'h000001;
      last = '{1'b1, ok, l, r, cmp, fam, {l, r, 8'h5A}, cnt, ~cnt};
      frame_out <= last;
      if (slow) begin
        @(posedge sys_clk_in);
        g = ~last;
        g.stb = 1'b0;
        frame_out <= g;
      end
    end
    @(posedge sys_clk_in);
    g = ~last;
    g.stb = 1'b0;
    frame_out <= g;
  endtask
endmodule

// >>> bench/srs_status_checker.sv
`timescale 1ns/100ps
module srs_status_checker (
  input wire logic                sys_clk_in,
  input wire logic                rst_in,
  input wire logic                hsel_in,
  input wire logic [31:0]         haddr_in,
  input wire logic [1:0]          htrans_in,
  input wire logic                hwrite_in,
  input wire logic [2:0]          hsize_in,
  input wire logic [31:0]         hwdata_in,
  input wire logic                hready_in,
  input wire srs_pkg::srs_frame_s frame_in,
  input wire logic                hreadyout_out,
  input wire logic [31:0]         hrdata_out,
  input wire logic                hresp_out,
  input wire srs_pkg::srs_audio_s audio_out,
  input wire logic                mute_out,
  input wire logic                irq_out
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  logic [6:0] run_ff;
  logic [3:0] wr_ff;
  wire        rq_w   = hsel_in && hready_in && htrans_in == srs_pkg::HTRANS_NONSEQ && hsize_in == srs_pkg::HSIZE_WORD;
  wire        good_w = frame_in.stb && frame_in.ok;
  wire        bad_w  = frame_in.stb && !frame_in.ok;

  // Saturates so a long run never wraps back under the lock threshold
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      run_ff <= 7'h00;
      wr_ff  <= 4'h0;
    end else begin
      wr_ff  <= {wr_ff[2:0], rq_w && hwrite_in};
      run_ff <= bad_w ? 7'h00 : (good_w && run_ff != 7'h7F) ? run_ff + 7'h01 : run_ff;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  property p_resp; hresp_out == 1'b0; endproperty
  a_resp: assert property (p_resp) else $error("response not okay");
  property p_upper; hrdata_out[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_rd_wait; rq_w && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_fast; rq_w && hwrite_in |=> hreadyout_out; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_mute_loss; bad_w |-> ##2 mute_out; endproperty
  a_mute_loss: assert property (p_mute_loss) else $error("no mute on loss");
  property p_mute_zero; mute_out |-> audio_out.left == 24'h000000 && audio_out.right == 24'h000000; endproperty
  a_mute_zero: assert property (p_mute_zero) else $error("audio while muted");
  property p_mute_hold; mute_out && !good_w && !$past(good_w) && wr_ff == 4'h0 |=> mute_out; endproperty
  a_mute_hold: assert property (p_mute_hold) else $error("unmute without cause");
  property p_lock_count; $fell(mute_out) |-> run_ff >= 7'h08; endproperty
  a_lock_count: assert property (p_lock_count) else $error("unmute before lock");

  c_unmute: cover property ($fell(mute_out));
  c_loss: cover property (bad_w && !mute_out);
  c_irq: cover property ($rose(irq_out));
endmodule

bind srs_status_top srs_status_checker u_chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .frame_in(frame_in), .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out),
  .hresp_out(hresp_out), .audio_out(audio_out), .mute_out(mute_out), .irq_out(irq_out)
);

// >>> bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                sys_clk_in;
  logic                rst_in = 1'b1;
  logic                hsel = 1'b0;
  logic [31:0]         haddr = 32'h0;
  logic [1:0]          htrans = 2'h0;
  logic                hwrite = 1'b0;
  logic [31:0]         hwdata = 32'h0;
  logic                hready;
  logic [31:0]         hrdata;
  logic                hresp;
  logic                mute;
  logic                irq;
  srs_pkg::srs_frame_s frame;
  srs_pkg::srs_audio_s audio;
  int                  num_errors = 0;
  int                  checked = 0;
  int                  cyc = 0;
  logic [31:0]         rd;
  logic [15:0]         code_exp = 16'h0000;
  logic [3:0]          wls [10] = '{srs_pkg::WL16, srs_pkg::WL17, srs_pkg::WL18, srs_pkg::WL19, srs_pkg::WL20,
                                    srs_pkg::WL20M24, srs_pkg::WL21, srs_pkg::WL22, srs_pkg::WL23, srs_pkg::WL24};

  srs_status_top dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(srs_pkg::HSIZE_WORD), .hwdata_in(hwdata), .hready_in(hready),
    .frame_in(frame), .hreadyout_out(hready), .hrdata_out(hrdata), .hresp_out(hresp),
    .audio_out(audio), .mute_out(mute), .irq_out(irq)
  );
  srs_src_model src (.sys_clk_in(sys_clk_in), .frame_out(frame));

  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      $display("[FAIL] %0t run timed out", $time);
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge sys_clk_in);
    hsel   <= 1'b1;
    haddr  <= {14'h0000, idx, 2'b00};
    htrans <= srs_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge sys_clk_in); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk_in); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask
  // Polls a settled pin for a few cycles, since unmute latency is not fixed
  task automatic pin(input logic sel, input logic exp);
    logic v;
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk_in);
      v = sel ? irq : mute;
      if (v === exp) break;
    end
    chk({31'h0, v}, {31'h0, exp});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(srs_pkg::IDX_LOCK, 32'h0);
    rchk(srs_pkg::IDX_DECODE, 32'h0);
    rchk(srs_pkg::IDX_CODE, 32'h0);
    rchk(srs_pkg::IDX_RESUME, 32'h0);
    rchk(srs_pkg::IDX_STICKY, 32'h0);
    rchk(16'hF6FF, 32'h0);
    pin(1'b0, 1'b1);
  endtask
  task automatic t_lock();
    bus(1'b1, srs_pkg::IDX_IRQ_CLR, 32'h7);
    src.send(63, 1'b1, srs_pkg::WL16, srs_pkg::WL24, 1'b0, 1'b0, 1'b1);
    rchk(srs_pkg::IDX_LOCK, 32'h0);
    src.send(1, 1'b1, srs_pkg::WL16, srs_pkg::WL24, 1'b0, 1'b0, 1'b0);
    rchk(srs_pkg::IDX_LOCK, 32'h1);
    rchk(srs_pkg::IDX_STICKY, 32'h0);
    pin(1'b0, 1'b0);
  endtask
  task automatic t_format();
    for (int i = 0; i < 10; i++) begin
      src.send(1, 1'b1, wls[i], wls[9 - i], i[0], i[1], 1'b0);
      if (i[0]) code_exp = {wls[i], wls[9 - i], 8'h5A};
      rchk(srs_pkg::IDX_DECODE, {22'h0, wls[9 - i], wls[i], i[1] & i[0], i[0]});
      rchk(srs_pkg::IDX_CODE, {16'h0, code_exp});
    end
    src.send(1, 1'b1, 4'hF, srs_pkg::WL20, 1'b0, 1'b1, 1'b0);
    rchk(srs_pkg::IDX_DECODE, {22'h0, srs_pkg::WL20, 4'h0, 2'b00});
    bus(1'b1, srs_pkg::IDX_DECODE, 32'hFFFF);
    rchk(srs_pkg::IDX_DECODE, {22'h0, srs_pkg::WL20, 4'h0, 2'b00});
    bus(1'b1, srs_pkg::IDX_STICKY, 32'h1);
    rchk(srs_pkg::IDX_STICKY, 32'h0);
  endtask
  task automatic t_manual();
    bus(1'b1, srs_pkg::IDX_IRQ_EN, 32'h2);
    src.send(1, 1'b0, srs_pkg::WL16, srs_pkg::WL16, 1'b0, 1'b0, 1'b0);
    pin(1'b0, 1'b1);
    pin(1'b1, 1'b1);
    rchk(srs_pkg::IDX_STICKY, 32'h1);
    bus(1'b0, srs_pkg::IDX_IRQ_ST, 32'h0);
    chk(rd & 32'h2, 32'h2);
    src.send(64, 1'b1, srs_pkg::WL16, srs_pkg::WL16, 1'b0, 1'b0, 1'b0);
    rchk(srs_pkg::IDX_LOCK, 32'h1);
    pin(1'b0, 1'b1);
    rchk(srs_pkg::IDX_STICKY, 32'h1);
    bus(1'b1, srs_pkg::IDX_IRQ_EN, 32'h0);
    pin(1'b1, 1'b0);
    bus(1'b1, srs_pkg::IDX_IRQ_EN, 32'h2);
    pin(1'b1, 1'b1);
    bus(1'b1, srs_pkg::IDX_IRQ_CLR, 32'h2);
    pin(1'b1, 1'b0);
    bus(1'b1, srs_pkg::IDX_RESUME, 32'h1);
    rchk(srs_pkg::IDX_RESUME, 32'h1);
    rchk(srs_pkg::IDX_STICKY, 32'h0);
    bus(1'b1, srs_pkg::IDX_RESUME, 32'h0);
    src.send(2, 1'b1, srs_pkg::WL16, srs_pkg::WL16, 1'b0, 1'b0, 1'b0);
    pin(1'b0, 1'b0);
    rchk(srs_pkg::IDX_STICKY, 32'h0);
  endtask
  task automatic t_auto();
    bus(1'b1, srs_pkg::IDX_CTRL, 32'h8);
    rchk(srs_pkg::IDX_CTRL, 32'h8);
    bus(1'b1, srs_pkg::IDX_RESUME, 32'h1);
    src.send(1, 1'b0, srs_pkg::WL16, srs_pkg::WL16, 1'b0, 1'b0, 1'b0);
    pin(1'b0, 1'b1);
    src.send(7, 1'b1, srs_pkg::WL16, srs_pkg::WL16, 1'b0, 1'b0, 1'b1);
    rchk(srs_pkg::IDX_LOCK, 32'h0);
    pin(1'b0, 1'b1);
    src.send(1, 1'b1, srs_pkg::WL16, srs_pkg::WL16, 1'b0, 1'b0, 1'b0);
    rchk(srs_pkg::IDX_LOCK, 32'h1);
    pin(1'b0, 1'b0);
    rchk(srs_pkg::IDX_STICKY, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_lock();
    t_format();
    t_manual();
    t_auto();
    conclude();
  end
endmodule
